// >>> verilog/prs_pkg.sv
// constants for the payload rate search and loopback control block
// Operation
// - line loopback bit set returns optical receive data to optical transmit
// - host loopback bit set returns host serial input to host output
// - rate search runs only in wrapper mode, after power-up or reset
// - after reset the rate is Ethernet payload with wrapping enabled
// - leaving initialization, check host data against the configured rate
// - Ethernet sync failure switches to SONET/SDH rate and checks again
// - without sync keep alternating rates about every 5 seconds
// - no host signal freezes the search until data returns
// - host data synchronized at any step ends the search
// - during the search laser stays off and not-ready stays asserted
// - rate field always shows the payload rate in use
// - any write to lower register 1 ends the search
// - any write to transport setup register page 3 address 128 ends search
// - writing 0 to search enable bit ends and disables the search
// - no traffic passes unless configured for the received payload rate; here traffic passes once the search ends or is skipped, locked or not
// - falling edge on power-down/reset pin gives a full reset, search restarts
`default_nettype none
package prs_pkg;
  localparam logic [7:0] ADDR_RATE_LB    = 8'h01;  // lower memory, any page
  localparam logic [7:0] ADDR_XPORT_SET  = 8'h80;  // page 3, 128
  localparam logic [7:0] ADDR_SEARCH_CFG = 8'hc0;  // page 3, 192
  localparam logic [7:0] PAGE_XPORT      = 8'h03;
  localparam logic [7:0] UPPER_BASE      = 8'h80;
  localparam int         RATE_MSB        = 7;
  localparam int         RATE_LSB        = 4;
  localparam int         LINE_LB_BIT     = 2;
  localparam int         HOST_LB_BIT     = 1;
  localparam int         SEARCH_EN_BIT   = 2;
  localparam int         WRAP_EN_BIT     = 0;
  localparam logic [3:0] RATE_ETH        = 4'h1;   // 10.3125 Gbps payload
  localparam logic [3:0] RATE_SONET      = 4'h2;   // 9.953 Gbps payload
  localparam logic [7:0] RATE_LB_RESET   = 8'h10;
  localparam logic [7:0] XPORT_RESET     = 8'h01;  // wrapping on
  localparam logic [7:0] SEARCH_RESET    = 8'h04;  // search enabled
  localparam int         CLK_MHZ         = 200;
  localparam int         SWITCH_SEC      = 5;
  localparam longint     SWITCH_CYC      = longint'(SWITCH_SEC) * CLK_MHZ * 1000000;
  localparam int         DATA_W          = 16;
  typedef enum logic [1:0] {PRS_INIT, PRS_SEARCH, PRS_DONE} prs_state_e;
endpackage
`default_nettype wire

// >>> verilog/prs_top.sv
// payload rate search, loopback select and management registers
`default_nettype none
module prs_top
  import prs_pkg::*;
#(
  parameter logic [31:0] SWITCH_CYCLES = 32'(SWITCH_CYC)
) (
  input  wire logic              i_mclk,             // 200 MHz clock
  input  wire logic              i_reset_n,          // async reset, active low
  input  wire logic              i_pdown_rst,        // power-down/reset pin, high = stand-by
  input  wire logic              i_tx_disable,       // transmitter disable pin
  input  wire logic              i_host_sig_detect,  // host serial signal present (pin)
  input  wire logic              i_host_sync,        // host data locked to set rate (pin)
  input  wire logic              i_reg_wr,           // register write strobe, same clock
  input  wire logic [7:0]        i_reg_page,         // selected upper page
  input  wire logic [7:0]        i_reg_addr,         // register address
  input  wire logic [7:0]        i_reg_wdata,        // write data
  output logic      [7:0]        o_reg_rdata,        // read data, registered
  input  wire logic [DATA_W-1:0] i_host_rx,          // host-side serial data in
  input  wire logic [DATA_W-1:0] i_optical_rx,       // optical receive data in
  output logic      [DATA_W-1:0] o_host_tx,          // data toward host
  output logic      [DATA_W-1:0] o_optical_tx,       // data toward fiber
  output logic      [3:0]        o_payload_rate,     // rate setting in use
  output logic                   o_laser_en,         // laser enable
  output logic                   o_module_not_ready  // not-ready indication
);

  logic [1:0] pdown_sync;
  logic [1:0] txdis_sync;
  logic [1:0] sig_sync;
  logic [1:0] lock_sync;
  logic       pdown_q;
  logic       soft_rst;
  prs_state_e state;
  logic [31:0] switch_cnt;
  logic [7:0] rate_lb;
  logic [7:0] xport_set;
  logic [7:0] search_cfg;
  logic       wr_rate_lb;
  logic       wr_xport;
  logic       wr_search;
  logic       terminate;
  logic       searching;
  logic       sig_ok;
  logic       locked;
  logic       switch_due;
  logic       toggle_now;

  // pins pass two flops before any logic reads them
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pdown_sync <= 2'h0;
      txdis_sync <= 2'h0;
      sig_sync   <= 2'h0;
      lock_sync  <= 2'h0;
    end else begin
      pdown_sync <= {pdown_sync[0], i_pdown_rst};
      txdis_sync <= {txdis_sync[0], i_tx_disable};
      sig_sync   <= {sig_sync[0], i_host_sig_detect};
      lock_sync  <= {lock_sync[0], i_host_sync};
    end
  end

  assign sig_ok = sig_sync[1];
  assign locked = lock_sync[1];

  // falling edge reset
  // pdown_q resets low, the pin's idle level, so no false edge follows reset
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pdown_q  <= 1'b0;
      soft_rst <= 1'b0;
    end else begin
      pdown_q  <= pdown_sync[1];
      soft_rst <= pdown_q & ~pdown_sync[1];
    end
  end

  assign wr_rate_lb = i_reg_wr && (i_reg_addr == ADDR_RATE_LB);
  assign wr_xport   = i_reg_wr && (i_reg_page == PAGE_XPORT) && (i_reg_addr == ADDR_XPORT_SET);
  assign wr_search  = i_reg_wr && (i_reg_page == PAGE_XPORT) && (i_reg_addr == ADDR_SEARCH_CFG);

  assign terminate = wr_rate_lb || wr_xport || (wr_search && !i_reg_wdata[SEARCH_EN_BIT]);

  assign searching  = (state == PRS_SEARCH);
  assign switch_due = (switch_cnt >= SWITCH_CYCLES - 32'h1);

  // a due switch waits until the host signal is back
  assign toggle_now = searching && sig_ok && !locked && switch_due;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= PRS_INIT;
    end else if (soft_rst) begin
      state <= PRS_INIT;
    end else begin
      unique case (state)
        PRS_INIT: begin
          if (xport_set[WRAP_EN_BIT] && search_cfg[SEARCH_EN_BIT] && !terminate) begin
            state <= PRS_SEARCH;
          end else begin
            state <= PRS_DONE;
          end
        end
        PRS_SEARCH: begin
          if (terminate || (sig_ok && locked)) begin
            state <= PRS_DONE;
          end
        end
        PRS_DONE: begin
          state <= PRS_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      switch_cnt <= 32'h0;
    end else if (soft_rst || !searching || (switch_due && sig_ok)) begin
      switch_cnt <= 32'h0;
    end else if (sig_ok) begin
      switch_cnt <= switch_cnt + 32'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rate_lb <= RATE_LB_RESET;
    end else if (soft_rst) begin
      rate_lb <= RATE_LB_RESET;
    end else if (wr_rate_lb) begin
      rate_lb <= i_reg_wdata;
    end else if (toggle_now) begin
      rate_lb[RATE_MSB:RATE_LSB] <= (rate_lb[RATE_MSB:RATE_LSB] == RATE_ETH) ?
                                    RATE_SONET : RATE_ETH;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      xport_set  <= XPORT_RESET;
      search_cfg <= SEARCH_RESET;
    end else if (soft_rst) begin
      xport_set  <= XPORT_RESET;
      search_cfg <= SEARCH_RESET;
    end else begin
      if (wr_xport) begin
        xport_set <= i_reg_wdata;
      end
      if (wr_search) begin
        search_cfg <= i_reg_wdata;
      end
    end
  end

  // lower memory ignores the page; unmapped reads return zero
  // read data is registered: it answers the address of the previous cycle
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_addr == ADDR_RATE_LB) begin
      o_reg_rdata <= rate_lb;
    end else if (i_reg_addr >= UPPER_BASE && i_reg_page == PAGE_XPORT &&
                 i_reg_addr == ADDR_XPORT_SET) begin
      o_reg_rdata <= xport_set;
    end else if (i_reg_page == PAGE_XPORT && i_reg_addr == ADDR_SEARCH_CFG) begin
      o_reg_rdata <= search_cfg;
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // data paths; loopback data always passes, other traffic is muted until the search has ended
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_optical_tx <= '0;
      o_host_tx    <= '0;
    end else begin
      if (rate_lb[LINE_LB_BIT]) begin
        o_optical_tx <= i_optical_rx;
      end else if (state == PRS_DONE) begin
        o_optical_tx <= i_host_rx;
      end else begin
        o_optical_tx <= '0;
      end
      if (rate_lb[HOST_LB_BIT]) begin
        o_host_tx <= i_host_rx;
      end else if (state == PRS_DONE) begin
        o_host_tx <= i_optical_rx;
      end else begin
        o_host_tx <= '0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_laser_en         <= 1'b0;
      o_module_not_ready <= 1'b1;
      o_payload_rate     <= RATE_ETH;
    end else begin
      // stand-by turns the laser off at once, before the soft reset follows
      o_laser_en         <= (state == PRS_DONE) && !txdis_sync[1] && !pdown_sync[1];
      o_module_not_ready <= (state != PRS_DONE) || pdown_sync[1];
      o_payload_rate     <= rate_lb[RATE_MSB:RATE_LSB];
    end
  end

endmodule
`default_nettype wire

// >>> sim/prs_top_monitor.sv
// assertion checker for the payload rate search block
`default_nettype none
module prs_top_monitor
  import prs_pkg::*;
(
  input wire logic              i_mclk,            // clock
  input wire logic              i_reset_n,         // reset
  input wire logic              i_pdown_rst,       // stand-by pin
  input wire logic              i_tx_disable,      // laser off pin
  input wire logic              i_reg_wr,          // write strobe
  input wire logic [7:0]        i_reg_page,        // page
  input wire logic [7:0]        i_reg_addr,        // address
  input wire logic [7:0]        i_reg_wdata,       // write data
  input wire logic [DATA_W-1:0] i_host_rx,         // host data in
  input wire logic [DATA_W-1:0] i_optical_rx,      // fiber data in
  input wire logic [DATA_W-1:0] o_host_tx,         // to host
  input wire logic [DATA_W-1:0] o_optical_tx,      // to fiber
  input wire logic [3:0]        o_payload_rate,    // rate in use
  input wire logic              o_laser_en,        // laser on
  input wire logic              o_module_not_ready // not ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] lb;
  logic [3:0] pd_hist;
  wire logic w1 = i_reg_wr && i_reg_addr == ADDR_RATE_LB;
  wire logic w3 = i_reg_wr && i_reg_page == PAGE_XPORT;
  // stand-by and the soft reset that trails the pin clear the copy early,
  // so checks go quiet rather than fire falsely
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lb      <= 2'h0;
      pd_hist <= 4'h0;
    end else begin
      pd_hist <= {pd_hist[2:0], i_pdown_rst};
      if (i_pdown_rst || pd_hist != 4'h0) begin
        lb <= 2'h0;
      end else if (w1) begin
        lb <= {i_reg_wdata[LINE_LB_BIT], i_reg_wdata[HOST_LB_BIT]};
      end
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  sequence s_awake; !i_pdown_rst [*8]; endsequence
  property p_nr_laser; o_module_not_ready |-> !o_laser_en; endproperty
  a_nr_laser: assert property (p_nr_laser) else $error("laser on while not ready");
  property p_txd; i_tx_disable [*5] |-> !o_laser_en; endproperty
  a_txd: assert property (p_txd) else $error("laser on while disabled");
  property p_rate;
    s_awake ##0 w1 |-> ##2 {4'h0, o_payload_rate} == ($past(i_reg_wdata, 2) >> 4);
  endproperty
  a_rate: assert property (p_rate) else $error("rate output not as written");
  property p_w1_end; s_awake ##0 w1 |-> ##2 !o_module_not_ready; endproperty
  a_w1_end: assert property (p_w1_end) else $error("rate write kept search");
  property p_xp_end;
    s_awake ##0 (w3 && i_reg_addr == ADDR_XPORT_SET) |-> ##2 !o_module_not_ready;
  endproperty
  a_xp_end: assert property (p_xp_end) else $error("setup write kept search");
  property p_off_end;
    s_awake ##0 (w3 && i_reg_addr == ADDR_SEARCH_CFG && !i_reg_wdata[SEARCH_EN_BIT])
      |-> ##2 !o_module_not_ready;
  endproperty
  a_off_end: assert property (p_off_end) else $error("disable kept search");
  property p_line_lb; $past(lb[1]) |-> o_optical_tx == $past(i_optical_rx); endproperty
  a_line_lb: assert property (p_line_lb) else $error("line loopback data wrong");
  property p_host_lb; $past(lb[0]) |-> o_host_tx == $past(i_host_rx); endproperty
  a_host_lb: assert property (p_host_lb) else $error("host loopback data wrong");
  c_write: cover property (w1);
  c_ready: cover property ($fell(o_module_not_ready));
  c_toggle: cover property ($changed(o_payload_rate));
endmodule
bind prs_top prs_top_monitor u_mon (
  .i_mclk             (i_mclk),
  .i_reset_n          (i_reset_n),
  .i_pdown_rst        (i_pdown_rst),
  .i_tx_disable       (i_tx_disable),
  .i_reg_wr           (i_reg_wr),
  .i_reg_page         (i_reg_page),
  .i_reg_addr         (i_reg_addr),
  .i_reg_wdata        (i_reg_wdata),
  .i_host_rx          (i_host_rx),
  .i_optical_rx       (i_optical_rx),
  .o_host_tx          (o_host_tx),
  .o_optical_tx       (o_optical_tx),
  .o_payload_rate     (o_payload_rate),
  .o_laser_en         (o_laser_en),
  .o_module_not_ready (o_module_not_ready)
);
`default_nettype wire

// >>> sim/prs_host_model.sv
// host side model: signal presence and rate lock seen by the block
`default_nettype none
module prs_host_model (
  input  wire logic       i_mclk,       // clock
  input  wire logic       i_present,    // host sends data
  input  wire logic [3:0] i_host_rate,  // rate the host sends
  input  wire logic [3:0] i_rate,       // rate the block uses
  output logic            o_sig_detect, // signal present
  output logic            o_sync        // data locked
);
  timeunit 1ns;
  timeprecision 1ps;
  // lock only with data present and a matching rate
  always_ff @(posedge i_mclk) begin
    o_sig_detect <= i_present;
    o_sync       <= i_present && i_rate == i_host_rate;
  end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the payload rate search block
`default_nettype none
`define CHK(n, e, a) chk(n, 16'(e), 16'(a))
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import prs_pkg::*;
  localparam int SW = 20;
  logic clk = 0, rst_n = 0, pdown = 0, txd = 0, wr = 0, present = 0, sig, sync, laser, nr;
  logic [7:0] page = 0, addr = 0, wd = 0, rd, v;
  logic [3:0] hrate = 0, rate;
  logic [DATA_W-1:0] hrx = 0, orx = 0, htx, otx, p_h, p_o;
  int n_errors = 0, comparisons = 0, m_rate, gap;
  int q[$];
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    hrx <= DATA_W'($urandom);
    orx <= DATA_W'($urandom);
    p_h <= hrx;
    p_o <= orx;
  end
  prs_top #(.SWITCH_CYCLES(32'(SW))) uut (.i_mclk(clk), .i_reset_n(rst_n),
    .i_pdown_rst(pdown), .i_tx_disable(txd), .i_host_sig_detect(sig), .i_host_sync(sync),
    .i_reg_wr(wr), .i_reg_page(page), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rd),
    .i_host_rx(hrx), .i_optical_rx(orx), .o_host_tx(htx), .o_optical_tx(otx),
    .o_payload_rate(rate), .o_laser_en(laser), .o_module_not_ready(nr));
  prs_host_model host (.i_mclk(clk), .i_present(present), .i_host_rate(hrate),
    .i_rate(rate), .o_sig_detect(sig), .o_sync(sync));
  task automatic chk(string n, logic [15:0] e, logic [15:0] a);
    comparisons++;
    if (a !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(logic [7:0] p, a, d);
    @(posedge clk);
    wr <= 1; page <= p; addr <= a; wd <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rreg(logic [7:0] p, a, output logic [7:0] d);
    @(posedge clk);
    page <= p; addr <= a;
    tick(1);
    d = rd;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rst_n <= 0;
    tick(5);
    @(posedge clk);
    rst_n <= 1;
    m_rate = RATE_ETH;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
  initial begin
    void'($urandom(32'hadf6));
    do_reset;
    rreg(8'h00, ADDR_RATE_LB, v);
    `CHK("rate reg", RATE_LB_RESET, v);
    rreg(PAGE_XPORT, ADDR_XPORT_SET, v);
    `CHK("setup reg", XPORT_RESET, v);
    rreg(PAGE_XPORT, ADDR_SEARCH_CFG, v);
    `CHK("search reg", SEARCH_RESET, v);
    tick(3 * SW);
    `CHK("frozen rate", m_rate, rate);
    `CHK("muted", 0, otx);
    $display("test reset and freeze done");
    @(posedge clk);
    present <= 1; hrate <= 4'h3;
    q = '{RATE_SONET, RATE_ETH, RATE_SONET};
    foreach (q[k]) begin
      gap = 0;
      while (rate === 4'(m_rate) && gap < 3 * SW) begin tick(1); gap++; end
      m_rate = q[k];
      `CHK("search rate", m_rate, rate);
      if (k > 0) `CHK("spacing", 1, gap >= SW - 1 && gap <= SW + 1);
      `CHK("search nr", 2'b01, {laser, nr});
    end
    // the host's rate now comes up on the next switch
    @(posedge clk);
    hrate <= RATE_ETH;
    for (int i = 0; i < 4 * SW && nr !== 1'b0; i++) tick(1);
    tick(1);
    `CHK("locked", 2'b10, {laser, nr});
    tick(2 * SW);
    `CHK("kept rate", RATE_ETH, rate);
    `CHK("traffic", p_h, otx);
    @(posedge clk);
    txd <= 1;
    tick(6);
    `CHK("tx off", 0, laser);
    @(posedge clk);
    txd <= 0;
    $display("test search done");
    // the block's only counter is the switch timer, cleared by every reset, so none need normalizing
    @(posedge clk);
    present <= 0;
    for (int k = 0; k < 3; k++) begin
      do_reset;
      tick(3);
      v = k == 0 ? {RATE_SONET, 1'b0, 3'($urandom)} : 8'h00;
      wreg(k == 0 ? 8'h00 : PAGE_XPORT, k == 0 ? ADDR_RATE_LB : k == 1 ? ADDR_XPORT_SET
           : ADDR_SEARCH_CFG, v);
      tick(3);
      `CHK("ended", 0, nr);
      `CHK("end rate", k == 0 ? RATE_SONET : RATE_ETH, rate);
    end
    $display("test terminations done");
    wreg(8'h00, ADDR_RATE_LB, {RATE_ETH, 4'h6});
    tick(2);
    for (int i = 0; i < 8; i++) begin
      tick(1);
      `CHK("line loop", p_o, otx);
      `CHK("host loop", p_h, htx);
    end
    $display("test loopback done");
    @(posedge clk);
    pdown <= 1;
    tick(4);
    `CHK("stand-by", 2'b01, {laser, nr});
    @(posedge clk);
    pdown <= 0;
    tick(8);
    `CHK("restart nr", 1, nr);
    rreg(8'h00, ADDR_RATE_LB, v);
    `CHK("restart reg", RATE_LB_RESET, v);
    $display("test soft reset done");
    end_sim;
  end
endmodule
`default_nettype wire
